// ---- power_budget_assertions.sv ----
// Checker for the power budget capability registers
`timescale 1ns/1ps
`default_nettype none
module power_budget_assertions (
    // Clock, reset and watched ports
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [11:0] cfg_addr_in,
    input wire logic cfg_write_in,
    input wire logic cfg_read_in,
    input wire logic [3:0] cfg_byte_enable_in,
    input wire logic [31:0] cfg_wdata_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_rvalid_out,
    input wire logic [7:0] selector_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_rd(x, ok);
        cfg_read_in && cfg_addr_in == x && ok;
    endsequence
    sequence s_sel_wr;
        cfg_write_in && cfg_addr_in == 12'h210 && cfg_byte_enable_in[0];
    endsequence
    a_header_word: assert property (s_rd(12'h20C, 1'b1) |=> cfg_rdata_out == 32'h00010004)
        else $error("header word wrong");
    a_sel_readback: assert property (s_rd(12'h210, 1'b1) |=> cfg_rdata_out == {24'h0, $past(selector_out)})
        else $error("selector readback wrong");
    a_sel_write: assert property (s_sel_wr |=> selector_out == $past(cfg_wdata_in[7:0]))
        else $error("selector not written");
    a_sel_hold: assert property (!(cfg_write_in && cfg_addr_in == 12'h210 && cfg_byte_enable_in[0])
        |=> $stable(selector_out)) else $error("selector changed");
    a_unsupported_zero: assert property (s_rd(12'h214, selector_out > 8'h01) |=> cfg_rdata_out == 32'h0)
        else $error("unsupported record not zero");
    a_fixed_fields: assert property (s_rd(12'h214, selector_out < 8'h02) |=>
        cfg_rdata_out[31:18] == 14'h0002 && cfg_rdata_out[12:10] == 3'h0) else $error("fixed fields wrong");
    a_read_answer: assert property (cfg_read_in |=> cfg_rvalid_out)
        else $error("read not answered");
    a_idle_quiet: assert property (!cfg_read_in |=> !cfg_rvalid_out && cfg_rdata_out == 32'h0)
        else $error("read data without read");
endmodule // power_budget_assertions
bind power_budget_capability_regs power_budget_assertions power_budget_assertions_inst (
    .mclk_in, .resetn_in, .cfg_addr_in, .cfg_write_in, .cfg_read_in, .cfg_byte_enable_in,
    .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .selector_out);
`default_nettype wire

// ---- power_budget_capability_regs.sv ----
// Power budgeting extended capability registers: header, selector and data
`timescale 1ns/1ps
`default_nettype none

module power_budget_capability_regs (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Configuration register access
    input wire logic [11:0] cfg_addr_in,
    input wire logic cfg_write_in,
    input wire logic cfg_read_in,
    input wire logic [3:0] cfg_byte_enable_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Autoload of record defaults
    input wire logic autoload_valid_in,
    input wire logic autoload_index_in,
    input wire logic [7:0] autoload_base_power_in,
    input wire logic [1:0] autoload_scale_in,
    input wire logic [1:0] autoload_state_in,
    input wire logic [2:0] autoload_cond_type_in,
    // Current selector for other logic
    output logic [7:0] selector_out
);

    // ********************************
    // Register state
    // ********************************
    logic [7:0] selector;
    logic [7:0] base_power [power_budget_pkg::RECORD_COUNT];
    logic [1:0] scale [power_budget_pkg::RECORD_COUNT];
    logic [1:0] state_code [power_budget_pkg::RECORD_COUNT];
    logic [2:0] cond_type [power_budget_pkg::RECORD_COUNT];
    logic [31:0] rdata;
    logic rvalid;

    // ********************************
    // Address decode
    // ********************************
    wire logic hit_header;
    wire logic hit_selector;
    wire logic hit_data;
    wire logic selector_write;

    assign hit_header = (cfg_addr_in == power_budget_pkg::CAP_HEADER_OFFSET);
    assign hit_selector = (cfg_addr_in == power_budget_pkg::SELECTOR_OFFSET);
    assign hit_data = (cfg_addr_in == power_budget_pkg::DATA_OFFSET);
    // Only the low byte lane holds writable bits; header and data have no write path
    assign selector_write = cfg_write_in && hit_selector && cfg_byte_enable_in[0];

    // ********************************
    // Selector next value
    // ********************************
    wire logic [7:0] next_selector;

    // Bits 31:8 of the write data never reach a flop, so reserved bits stay zero
    assign next_selector = selector_write ?
                           cfg_wdata_in[power_budget_pkg::SELECTOR_MSB:power_budget_pkg::SELECTOR_LSB] :
                           selector;

    // ********************************
    // Capability header
    // ********************************
    wire logic [31:0] header_word;
    wire logic [31:0] selector_word;

    // Fixed in hardware with no write path, so software cannot move the chain end
    assign header_word = {power_budget_pkg::NEXT_POINTER,
                          power_budget_pkg::CAP_VERSION,
                          power_budget_pkg::CAP_IDENTIFIER};
    assign selector_word = {24'h000000, selector};

    // ********************************
    // Record selection
    // ********************************
    wire logic record_valid;
    wire logic record_index;

    assign record_valid = (selector == power_budget_pkg::SELECT_MAX) ||
                          (selector == power_budget_pkg::SELECT_SUSTAINED);
    assign record_index = selector[0];

    // ********************************
    // Fields of the selected record
    // ********************************
    wire logic [7:0] field_base_power;
    wire logic [1:0] field_scale;
    wire logic [2:0] field_substate;
    wire logic [1:0] field_state;
    wire logic [2:0] field_cond_type;
    wire logic [2:0] field_rail;
    wire logic [31:0] data_word;

    // Unsupported indexes read a fully zero word, rail included
    assign field_base_power = record_valid ? base_power[record_index] : 8'h00;
    assign field_scale = record_valid ? scale[record_index] : 2'h0;
    assign field_substate = record_valid ? power_budget_pkg::SUBSTATE_RESET : 3'h0;
    assign field_state = record_valid ? state_code[record_index] : 2'h0;
    assign field_cond_type = record_valid ? cond_type[record_index] : 3'h0;
    assign field_rail = record_valid ? power_budget_pkg::RAIL_RESET : 3'h0;

    assign data_word = {11'h000,
                        field_rail,
                        field_cond_type,
                        field_state,
                        field_substate,
                        field_scale,
                        field_base_power};

    // ********************************
    // Read data selection
    // ********************************
    wire logic [31:0] read_word;
    wire logic [31:0] next_rdata;
    wire logic next_rvalid;

    // Unmapped addresses answer with zero rather than stalling the bus
    assign read_word = hit_header ? header_word :
                       hit_selector ? selector_word :
                       hit_data ? data_word : 32'h00000000;
    // Zero whenever no read was taken, so a stale word never lingers on the bus
    assign next_rdata = cfg_read_in ? read_word : 32'h00000000;
    assign next_rvalid = cfg_read_in;

    // ********************************
    // Selector
    // ********************************
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            selector <= power_budget_pkg::SELECTOR_RESET;
        end else begin
            selector <= next_selector;
        end
    end

    // ********************************
    // Record storage
    // ********************************
    wire logic [power_budget_pkg::RECORD_COUNT-1:0] record_load;

    genvar i;
    generate
        for (i = 0; i < power_budget_pkg::RECORD_COUNT; i++) begin : g_record
            // Only the addressed record takes the load; the other keeps its values
            assign record_load[i] = autoload_valid_in && (autoload_index_in == 1'(i));

            always_ff @(posedge mclk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    base_power[i] <= power_budget_pkg::BASE_POWER_RESET;
                end else if (record_load[i]) begin
                    base_power[i] <= autoload_base_power_in;
                end
            end

            always_ff @(posedge mclk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    scale[i] <= power_budget_pkg::SCALE_RESET;
                end else if (record_load[i]) begin
                    scale[i] <= autoload_scale_in;
                end
            end

            always_ff @(posedge mclk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    state_code[i] <= power_budget_pkg::STATE_RESET;
                end else if (record_load[i]) begin
                    state_code[i] <= autoload_state_in;
                end
            end

            always_ff @(posedge mclk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    cond_type[i] <= power_budget_pkg::COND_TYPE_RESET;
                end else if (record_load[i]) begin
                    cond_type[i] <= autoload_cond_type_in;
                end
            end
        end
    endgenerate

    // ********************************
    // Read data
    // ********************************
    // Registered read keeps every output straight from a flip-flop, at one cycle of latency
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= next_rvalid;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign cfg_rdata_out = rdata;
    assign cfg_rvalid_out = rvalid;
    assign selector_out = selector;

endmodule // power_budget_capability_regs

`default_nettype wire

// ---- power_budget_pkg.sv ----
// Constants for the power budgeting extended capability register group
package power_budget_pkg;
    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [11:0] CAP_HEADER_OFFSET = 12'h20C;
    localparam logic [11:0] SELECTOR_OFFSET = 12'h210;
    localparam logic [11:0] DATA_OFFSET = 12'h214;

    // ********************************
    // Capability header values
    // ********************************
    localparam logic [15:0] CAP_IDENTIFIER = 16'h0004;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [11:0] NEXT_POINTER = 12'h000;

    // ********************************
    // Selector
    // ********************************
    localparam logic [7:0] SELECTOR_RESET = 8'h00;
    localparam logic [7:0] SELECT_MAX = 8'h00;
    localparam logic [7:0] SELECT_SUSTAINED = 8'h01;
    localparam int SELECTOR_LSB = 0;
    localparam int SELECTOR_MSB = 7;

    // ********************************
    // Data record fields: positions
    // ********************************
    localparam int BASE_POWER_LSB = 0;
    localparam int SCALE_LSB = 8;
    localparam int SUBSTATE_LSB = 10;
    localparam int STATE_LSB = 13;
    localparam int COND_TYPE_LSB = 15;
    localparam int RAIL_LSB = 18;
    localparam int RECORD_MSB = 20;

    // ********************************
    // Data record fields: reset values
    // ********************************
    localparam logic [7:0] BASE_POWER_RESET = 8'h04;
    localparam logic [1:0] SCALE_RESET = 2'h0;
    localparam logic [2:0] SUBSTATE_RESET = 3'h0;
    localparam logic [1:0] STATE_RESET = 2'h0;
    localparam logic [2:0] COND_TYPE_RESET = 3'h7;
    localparam logic [2:0] RAIL_RESET = 3'h2;

    // Number of supported records
    localparam int RECORD_COUNT = 2;
endpackage

// ---- test_power_budget_capability_regs.sv ----
// Self-checking bench for the power budget capability registers
`timescale 1ns/1ps
`default_nettype none
module test_power_budget_capability_regs;
    logic clk, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, al = 1'b0, ai = 1'b0, rv;
    logic [11:0] a = 12'h000;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0, rdat, r, d;
    logic [7:0] bp_in = 8'h00, sel_out, sel;
    logic [1:0] sc_in = 2'h0, st_in = 2'h0;
    logic [2:0] ct_in = 3'h0;
    logic [14:0] rec [2];
    logic [11:0] addrs [4] = '{12'h20C, 12'h210, 12'h214, 12'h3FC};
    int miscompares = 0, n_compared = 0, seed = 32'h07AC64F5;
    power_budget_capability_regs power_budget_capability_regs_inst (.mclk_in(clk), .resetn_in(rst_n),
        .cfg_addr_in(a), .cfg_write_in(wr), .cfg_read_in(rd), .cfg_byte_enable_in(be), .cfg_wdata_in(wd),
        .cfg_rdata_out(rdat), .cfg_rvalid_out(rv), .autoload_valid_in(al), .autoload_index_in(ai),
        .autoload_base_power_in(bp_in), .autoload_scale_in(sc_in), .autoload_state_in(st_in),
        .autoload_cond_type_in(ct_in), .selector_out(sel_out));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(string n, logic [31:0] s, logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic [31:0] exp_rd(logic [11:0] x);
        logic [14:0] q;
        q = rec[sel[0]];
        case (x)
            12'h20C: exp_rd = 32'h00010004;
            12'h210: exp_rd = {24'h0, sel};
            12'h214: exp_rd = (sel < 8'h02) ? {11'h0, 3'h2, q[2:0], q[4:3], 3'h0, q[6:5], q[14:7]} : 32'h0;
            default: exp_rd = 32'h0;
        endcase
    endfunction
    // Every input is assigned once per step, so back-to-back calls never glitch a strobe
    task op(logic r_i, logic w_i, logic [11:0] x, logic [3:0] b, logic [31:0] dat, logic l);
        logic [31:0] e;
        e = r_i ? exp_rd(x) : 32'h0;
        rd = r_i;
        wr = w_i;
        a = x;
        be = b;
        wd = dat;
        al = l;
        {ai, bp_in, sc_in, st_in, ct_in} = 16'($random(seed));
        @(posedge clk);
        #1;
        if (w_i && x == 12'h210 && b[0]) sel = dat[7:0];
        if (l) rec[ai] = {bp_in, sc_in, st_in, ct_in};
        chk("rvalid", {31'h0, rv}, {31'h0, r_i});
        chk("rdata", rdat, e);
        chk("selector", {24'h0, sel_out}, {24'h0, sel});
    endtask
    task do_reset;
        rst_n = 1'b0;
        sel = 8'h00;
        rec = '{2{15'h0207}};
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
    endtask
    task end_sim;
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        do_reset();
        op(1'b1, 1'b1, 12'h20C, 4'hF, 32'hFFFFFFFF, 1'b0);
        op(1'b1, 1'b1, 12'h214, 4'hF, 32'hFFFFFFFF, 1'b0);
        op(1'b1, 1'b1, 12'h210, 4'hE, 32'h00000001, 1'b0);
        op(1'b1, 1'b1, 12'h210, 4'h1, 32'hFFFFFF01, 1'b0);
        op(1'b1, 1'b1, 12'h214, 4'h1, 32'h00000000, 1'b0);
        op(1'b1, 1'b1, 12'h210, 4'h1, 32'h000000FF, 1'b0);
        repeat (800) begin
            r = $random(seed);
            d = $random(seed);
            d[7:1] = d[8] ? d[7:1] : 7'h00;
            op(r[0], r[1], addrs[r[3:2]], r[7:4], d, r[9]);
            if (r[31:22] == 10'h000) do_reset();
        end
        do_reset();
        op(1'b1, 1'b0, 12'h214, 4'h0, 32'h0, 1'b0);
        op(1'b1, 1'b0, 12'h210, 4'h0, 32'h0, 1'b0);
        op(1'b0, 1'b0, 12'h000, 4'h0, 32'h0, 1'b0);
        end_sim();
    end
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule // test_power_budget_capability_regs
`default_nettype wire
